//--- rtl/sfbl_pkg.sv
// Package with constants and types for the SPI flash boot loader
package sfbl_pkg;
    localparam logic [11:0] CTRL_OFFSET      = 12'h000;
    localparam logic [11:0] HDR_OFFSET       = 12'h004;
    localparam logic [11:0] STAT_OFFSET      = 12'h008;
    localparam int          START_BIT        = 0;
    localparam int          STOP_BIT         = 1;
    localparam int          DEST_BIT         = 2;
    localparam int          HSEL_BIT         = 3;
    localparam int          HTRANS0_BIT      = 4;
    localparam int          HTRANS1_BIT      = 5;
    localparam int          HREADY_BIT       = 6;
    localparam int          DMA_PEND_BIT     = 7;
    localparam int          BRG_PEND_BIT     = 8;
    localparam logic [31:0] CTRL_RESET       = 32'h00000000;
    localparam int          ID_MSB           = 31;
    localparam int          ID_LSB           = 24;
    localparam int          DIV_MSB          = 23;
    localparam int          DIV_LSB          = 16;
    localparam int          SIZE_MSB         = 15;
    localparam int          SIZE_LSB         = 0;
    // Required identifier; value is arbitrary
    localparam logic [7:0]  REQUIRED_ID      = 8'h5a;
    localparam logic [2:0]  MAX_ATTEMPTS     = 3'h4;
    localparam int          FRAME_BYTES      = 8;
    localparam int          CLK_HZ           = 125000000;
    localparam int          HDR_SCLK_HZ      = 643900;
    // Half period count of slow header clock, rounded down
    localparam int          HDR_HALF_CYC     = CLK_HZ / (2 * HDR_SCLK_HZ);
    localparam int          RETRY_DELAY_US   = 100;
    localparam int          RETRY_DELAY_CYC  = RETRY_DELAY_US * (CLK_HZ / 1000000);
    localparam logic [7:0]  CMD_READ         = 8'h03;
    localparam logic [7:0]  CMD_DEEP_SLEEP   = 8'hb9;
    localparam logic [23:0] HDR_ADDR         = 24'h000000;
    localparam logic [23:0] IMG_ADDR         = 24'h000004;
    localparam logic [31:0] MEM_BASE         = 32'h20000000;

    typedef struct packed {
        logic [7:0]  devId;
        logic [7:0]  clkDiv;
        logic [15:0] bootSize;
    } sfbl_header_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [31:0] data;
    } sfbl_wr_t;

    typedef struct packed {
        logic [7:0] txByte;
        logic       start;
        logic       last;
        logic       isRead;
        logic [8:0] divisor;
    } sfbl_spi_req_t;
endpackage

//--- rtl/sfbl_spi_master.sv
// Byte-wide SPI mode 0 shift engine on boot flash select line
`timescale 1ns/1ps
module sfbl_spi_master
    import sfbl_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rstn,
    input  wire sfbl_spi_req_t req,
    output logic               busy,
    output logic               byteDone,
    output logic [7:0]         rxByte,
    output logic               sclk,
    output logic               mosi,
    input  wire logic          miso,
    output logic               bootFlashSelectLine_n
);
    logic [8:0] divCnt;
    logic [3:0] bitCnt;
    logic [7:0] shReg;
    logic       keepSel;
    wire        tick = (divCnt == 9'h000);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            divCnt <= 9'h000; bitCnt <= 4'h0; shReg <= 8'h00; busy <= 1'b0;
            byteDone <= 1'b0; rxByte <= 8'h00; sclk <= 1'b0; mosi <= 1'b0;
            bootFlashSelectLine_n <= 1'b1; keepSel <= 1'b0;
        end else begin
            byteDone <= 1'b0;
            if (!busy && !byteDone && req.start) begin
                busy <= 1'b1; shReg <= req.txByte; mosi <= req.txByte[7];
                bitCnt <= 4'h0; divCnt <= req.divisor; keepSel <= !req.last;
                bootFlashSelectLine_n <= 1'b0;
            end else if (busy) begin
                divCnt <= tick ? req.divisor : divCnt - 9'h001;
                if (tick) begin
                    sclk <= !sclk;
                    if (!sclk) begin
                        shReg <= {shReg[6:0], miso};
                    end else begin
                        mosi <= shReg[7];
                        bitCnt <= bitCnt + 4'h1;
                        if (bitCnt == 4'h7) begin
                            busy <= 1'b0; byteDone <= 1'b1; rxByte <= shReg;
                            bootFlashSelectLine_n <= !keepSel;
                        end
                    end
                end
            end
        end
    end
endmodule // sfbl_spi_master

//--- rtl/sfbl_bus_bridge.sv
// Single-entry bridge from DMA words to a system-bus write master
`timescale 1ns/1ps
module sfbl_bus_bridge
    import sfbl_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire sfbl_wr_t    wr,
    output logic             accept,
    output logic             pending,
    output logic             hsel,
    output logic [1:0]       htrans,
    output logic [31:0]      haddr,
    output logic [31:0]      hwdata,
    output logic             hwrite,
    input  wire logic        hready
);
    logic dataPhase;
    logic [31:0] dataHold;
    assign accept = !pending;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pending <= 1'b0; dataPhase <= 1'b0; hsel <= 1'b0; htrans <= 2'b00;
            haddr <= 32'h00000000; hwdata <= 32'h00000000; hwrite <= 1'b0;
            dataHold <= 32'h00000000;
        end else begin
            if (wr.valid && !pending) begin
                pending <= 1'b1; hsel <= 1'b1; htrans <= 2'b10; hwrite <= 1'b1;
                haddr <= wr.addr; dataHold <= wr.data;
            end else if (pending && hready) begin
                if (!dataPhase) begin
                    dataPhase <= 1'b1; hwdata <= dataHold;
                    hsel <= 1'b0; htrans <= 2'b00; hwrite <= 1'b0;
                end else begin
                    dataPhase <= 1'b0; pending <= 1'b0;
                end
            end
        end
    end
endmodule // sfbl_bus_bridge

//--- rtl/spi_flash_boot_loader.sv
// Boot loader state machine with configuration DMA and APB control
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module spi_flash_boot_loader
    import sfbl_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             sclk,
    output logic             mosi,
    input  wire logic        miso,
    output logic             bootFlashSelectLine_n,
    output logic             hsel,
    output logic [1:0]       htrans,
    output logic [31:0]      haddr,
    output logic [31:0]      hwdata,
    output logic             hwrite,
    input  wire logic        hready,
    output logic             bootDone,
    output logic             bootError
);
    typedef enum {
        ST_HDR_CMD, ST_HDR_DATA, ST_HDR_CHECK, ST_RETRY_WAIT,
        ST_SLEEP_CMD, ST_ERROR, ST_IMG_CMD, ST_IMG_DATA, ST_IMG_DRAIN, ST_IDLE
    } sfbl_state_t;

    function automatic logic [8:0] boot_divisor(input logic [7:0] d);
        boot_divisor = {d, 1'b0};
    endfunction

    sfbl_state_t   state;
    sfbl_header_t  header;
    sfbl_spi_req_t spiReq;
    sfbl_wr_t      wrReq;
    logic [2:0]    attempts;
    logic [2:0]    cmdIdx;
    logic [1:0]    byteIdx;
    logic [31:0]   wordBuf;
    logic [31:0]   wordCnt;
    logic [31:0]   wordTotal;
    logic [31:0]   dstAddr;
    logic [23:0]   retryCnt;
    logic          dmaEnable;
    logic          dmaStop;
    logic          dmaDest;
    logic          pathBusy;
    logic          spiBusy;
    logic          spiByteDone;
    logic [7:0]    spiRx;
    logic          brAccept;
    logic          brPending;
    logic          brHsel;
    logic [1:0]    brHtrans;
    logic          brHwrite;

    wire        apbAccess  = psel && penable;
    wire        ctrlHit    = (paddr == CTRL_OFFSET);
    wire        hdrHit     = (paddr == HDR_OFFSET);
    wire        statHit    = (paddr == STAT_OFFSET);
    wire        ctrlLocked = pathBusy;
    wire        ctrlWrite  = apbAccess && pwrite && ctrlHit && !ctrlLocked;
    wire        idOk       = (header.devId == REQUIRED_ID);
    wire [31:0] ctrlView   = {23'h000000, brPending, (state == ST_IMG_DATA), hready,
                              brHtrans[1], brHtrans[0], brHsel, dmaDest, dmaStop,
                              dmaEnable};
    wire [31:0] statView   = {28'h0000000, attempts, bootError};
    wire [31:0] readMux    = ctrlHit ? (ctrlLocked ? 32'h00000000 : ctrlView) :
                             hdrHit  ? header :
                             statHit ? statView : 32'h00000000;
    wire        badAddr    = !(ctrlHit || hdrHit || statHit);
    wire        imgLast    = (wordCnt == wordTotal);
    wire [31:0] assembled  = {spiRx, wordBuf[31:8]};
    wire        inHeader   = (state == ST_HDR_CMD) || (state == ST_HDR_DATA);
    wire [7:0]  imgCmd     = (cmdIdx == 3'h0) ? CMD_READ :
                             (cmdIdx == 3'h1) ? IMG_ADDR[23:16] :
                             (cmdIdx == 3'h2) ? IMG_ADDR[15:8] : IMG_ADDR[7:0];
    wire [7:0]  hdrCmd     = (cmdIdx == 3'h0) ? CMD_READ :
                             (cmdIdx == 3'h1) ? HDR_ADDR[23:16] :
                             (cmdIdx == 3'h2) ? HDR_ADDR[15:8] : HDR_ADDR[7:0];

    // Slow clock for header and sleep, header-derived clock for image
    always_comb begin
        spiReq.divisor = inHeader || (state == ST_SLEEP_CMD) ?
                         9'(HDR_HALF_CYC - 1) : boot_divisor(header.clkDiv);
        spiReq.isRead  = 1'b1;
        spiReq.start   = 1'b0;
        spiReq.last    = 1'b0;
        spiReq.txByte  = 8'h00;
        case (state)
            ST_HDR_CMD: begin
                spiReq.start  = !spiBusy;
                spiReq.txByte = hdrCmd;
            end
            ST_HDR_DATA: begin
                spiReq.start = !spiBusy;
                spiReq.last  = (byteIdx == 2'h3);
            end
            ST_SLEEP_CMD: begin
                spiReq.start  = !spiBusy && (cmdIdx == 3'h0);
                spiReq.txByte = CMD_DEEP_SLEEP;
                spiReq.last   = 1'b1;
            end
            ST_IMG_CMD: begin
                spiReq.start  = !spiBusy;
                spiReq.txByte = imgCmd;
            end
            ST_IMG_DATA: begin
                spiReq.start = !spiBusy && brAccept && !wrReq.valid;
                spiReq.last  = imgLast && (byteIdx == 2'h3);
            end
            default: begin
                spiReq.start = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state <= ST_HDR_CMD; header <= '0; attempts <= 3'h0; cmdIdx <= 3'h0;
            byteIdx <= 2'h0; wordBuf <= 32'h00000000; wordCnt <= 32'h00000000;
            wordTotal <= 32'h00000000; dstAddr <= MEM_BASE; retryCnt <= 24'h000000;
            wrReq <= '0; bootDone <= 1'b0; bootError <= 1'b0; pathBusy <= 1'b1;
        end else begin
            wrReq.valid <= 1'b0;
            case (state)
                ST_HDR_CMD: if (spiByteDone) begin
                    cmdIdx <= cmdIdx + 3'h1;
                    if (cmdIdx == 3'h3) begin
                        state <= ST_HDR_DATA;
                        byteIdx <= 2'h0;
                    end
                end
                ST_HDR_DATA: if (spiByteDone) begin
                    header <= {header[23:0], spiRx};
                    byteIdx <= byteIdx + 2'h1;
                    if (byteIdx == 2'h3) begin
                        state <= ST_HDR_CHECK;
                        attempts <= attempts + 3'h1;
                    end
                end
                ST_HDR_CHECK: begin
                    cmdIdx <= 3'h0;
                    if (idOk) begin
                        state <= ST_IMG_CMD;
                        wordTotal <= ({16'h0000, header.bootSize} + 32'h1) *
                                     32'(FRAME_BYTES / 4) - 32'h1;
                        wordCnt <= 32'h00000000;
                        dstAddr <= MEM_BASE;
                    end else if (attempts == MAX_ATTEMPTS) begin
                        state <= ST_SLEEP_CMD;
                    end else begin
                        state <= ST_RETRY_WAIT;
                        retryCnt <= 24'(RETRY_DELAY_CYC - 1);
                    end
                end
                ST_RETRY_WAIT: begin
                    retryCnt <= retryCnt - 24'h000001;
                    if (retryCnt == 24'h000000) begin
                        state <= ST_HDR_CMD;
                    end
                end
                ST_SLEEP_CMD: begin
                    if (!spiBusy && cmdIdx == 3'h0) begin
                        cmdIdx <= 3'h1;
                    end
                    if (spiByteDone) begin
                        state <= ST_ERROR;
                        bootError <= 1'b1;
                        pathBusy <= 1'b0;
                    end
                end
                ST_ERROR: begin
                    state <= ST_ERROR;
                end
                ST_IMG_CMD: if (spiByteDone) begin
                    cmdIdx <= cmdIdx + 3'h1;
                    if (cmdIdx == 3'h3) begin
                        state <= ST_IMG_DATA;
                        byteIdx <= 2'h0;
                    end
                end
                ST_IMG_DATA: if (spiByteDone) begin
                    wordBuf <= assembled;
                    byteIdx <= byteIdx + 2'h1;
                    if (byteIdx == 2'h3) begin
                        wrReq.valid <= 1'b1;
                        wrReq.addr <= dstAddr;
                        wrReq.data <= assembled;
                        dstAddr <= dstAddr + 32'h4;
                        wordCnt <= wordCnt + 32'h1;
                        if (imgLast) begin
                            state <= ST_IMG_DRAIN;
                        end
                    end
                end
                ST_IMG_DRAIN: begin
                    if (!brPending && !wrReq.valid) begin
                        state <= ST_IDLE;
                        bootDone <= 1'b1;
                        pathBusy <= 1'b0;
                    end
                end
                ST_IDLE: begin
                    bootDone <= 1'b1;
                end
                default: begin
                    state <= ST_ERROR;
                end
            endcase
        end
    end

    // Control register and APB slave
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dmaEnable <= CTRL_RESET[START_BIT];
            dmaStop <= CTRL_RESET[STOP_BIT];
            dmaDest <= CTRL_RESET[DEST_BIT];
            prdata <= 32'h00000000; pready <= 1'b0; pslverr <= 1'b0;
        end else begin
            pready <= psel && !pready;
            pslverr <= psel && !pready && badAddr;
            if (psel && !pready && !pwrite) begin
                prdata <= readMux;
            end
            if (state == ST_IMG_DRAIN && !brPending && !wrReq.valid) begin
                dmaStop <= 1'b1;
                dmaEnable <= 1'b0;
            end else if (ctrlWrite && pready) begin
                if (pwdata[STOP_BIT]) begin
                    dmaStop <= 1'b0;
                    dmaEnable <= 1'b0;
                end else if (pwdata[START_BIT]) begin
                    dmaEnable <= 1'b1;
                end
                dmaDest <= pwdata[DEST_BIT];
            end
        end
    end

    sfbl_spi_master u_spi (
        .mclk                  (mclk),
        .rstn                  (rstn),
        .req                   (spiReq),
        .busy                  (spiBusy),
        .byteDone              (spiByteDone),
        .rxByte                (spiRx),
        .sclk                  (sclk),
        .mosi                  (mosi),
        .miso                  (miso),
        .bootFlashSelectLine_n (bootFlashSelectLine_n)
    );

    sfbl_bus_bridge u_bridge (
        .mclk    (mclk),
        .rstn    (rstn),
        .wr      (wrReq),
        .accept  (brAccept),
        .pending (brPending),
        .hsel    (brHsel),
        .htrans  (brHtrans),
        .haddr   (haddr),
        .hwdata  (hwdata),
        .hwrite  (brHwrite),
        .hready  (hready)
    );

    assign hsel   = brHsel;
    assign htrans = brHtrans;
    assign hwrite = brHwrite;
endmodule // spi_flash_boot_loader

//--- verification/sfbl_checker_sva.sv
// Assertions on the boot loader ports
`timescale 1ns/1ps
module sfbl_checker
    import sfbl_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        sclk,
    input wire logic        bootFlashSelectLine_n,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        bootDone,
    input wire logic        bootError
);
    logic [7:0] hiCnt;
    logic       firstFrame;
    logic       bootBusy;
    wire        ctrlRd = psel && penable && pready && !pwrite && paddr == CTRL_OFFSET;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Length of the current high phase of the serial clock
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            hiCnt      <= 8'h00;
            firstFrame <= 1'b1;
            bootBusy   <= 1'b1;
        end else begin
            hiCnt <= sclk ? hiCnt + 8'h01 : 8'h00;
            if ($rose(bootFlashSelectLine_n)) firstFrame <= 1'b0;
            if (bootDone || bootError) bootBusy <= 1'b0;
        end
    end
    sequence sErrEntry;
        !bootError ##1 bootError;
    endsequence
    AST_SEL_IDLE: assert property (bootFlashSelectLine_n |-> !sclk)
        else $error("serial clock moves while flash deselected");
    AST_HDR_SLOW: assert property (firstFrame && $fell(sclk) |-> hiCnt >= 8'h5a)
        else $error("header clock too fast");
    AST_ERR_HOLD: assert property (bootError |=> bootError)
        else $error("error state left without reset");
    AST_ERR_DESEL: assert property (sErrEntry |-> bootFlashSelectLine_n && !sclk)
        else $error("error entered with flash still selected");
    AST_NO_BUS_ERR: assert property (hsel |-> !bootError)
        else $error("image write after header failure");
    AST_BUS_WRITE: assert property (hsel |-> hwrite && htrans == 2'b10)
        else $error("bridge beat is not a write");
    AST_DONE_IDLE: assert property ($rose(bootDone) |-> !hsel && htrans == 2'b00)
        else $error("done while bridge busy");
    AST_UPPER_ZERO: assert property (ctrlRd |-> prdata[31:9] == 23'h0)
        else $error("upper control bits not zero");
    AST_BUSY_ZERO: assert property (ctrlRd && bootBusy |-> prdata == 32'h0)
        else $error("control visible during boot");
    AST_HREADY_LIVE: assert property (ctrlRd && !bootBusy && $stable(hready)
        |-> prdata[HREADY_BIT] == hready)
        else $error("ready bit not live");
endmodule // sfbl_checker

bind spi_flash_boot_loader sfbl_checker i_chk (.mclk, .rstn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .sclk, .bootFlashSelectLine_n, .hsel, .htrans, .hwrite, .hready,
    .bootDone, .bootError);

//--- verification/sfbl_flash_model.sv
// Behavioural SPI flash on the boot select line
`timescale 1ns/1ps
module sfbl_flash_model
    import sfbl_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         sclk,
    input  wire logic         mosi,
    input  wire logic         csN,
    input  wire sfbl_header_t hdr,
    output logic              miso = 1'b0,
    output int                readCmds = 0,
    output logic [7:0]        lastCmd = 8'h00,
    output logic [23:0]       lastAddr = 24'h0,
    output logic              sleeping = 1'b0
);
    int          bits = 0;
    logic [31:0] sh;
    logic [7:0]  dat;
    // Header word top byte first, image bytes after it
    function automatic logic [7:0] mem(input logic [23:0] a);
        if (a < 24'h4) return hdr[31 - 8 * int'(a[1:0]) -: 8];
        return a[7:0] ^ 8'ha5;
    endfunction
    always @(negedge csN) bits = 0;
    always @(posedge sclk) begin
        if (!csN) begin
            sh = {sh[30:0], mosi};
            bits++;
            if (bits == 8) lastCmd = sh[7:0];
            if (bits == 32) lastAddr = sh[23:0];
            if (bits == 32 && lastCmd == CMD_READ) readCmds++;
        end
    end
    // Data launched on the fall so it is settled at the next rise
    always @(negedge sclk) begin
        if (!csN && !sleeping && bits >= 32 && lastCmd == CMD_READ) begin
            dat = mem(lastAddr + 24'((bits - 32) / 8));
            miso <= dat[7 - (bits % 8)];
        end
    end
    // Released line flips so stale data never passes for a bit
    always @(posedge mclk) begin
        if (csN || sleeping) miso <= ~miso;
    end
    always @(posedge csN) begin
        if (bits == 8 && lastCmd == CMD_DEEP_SLEEP) sleeping = 1'b1;
    end
endmodule // sfbl_flash_model

//--- verification/tb.sv
// Self-checking testbench for the SPI flash boot loader
`timescale 1ns/1ps
module tb;
    import sfbl_pkg::*;
    logic         mclk = 1'b0;
    logic         rstn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0;
    logic         hready = 1'b1;
    logic         stall = 1'b0;
    logic         dPh = 1'b0;
    sfbl_header_t hdr = 32'h0;
    logic [31:0]  prdata, haddr, hwdata, r;
    logic         pready, pslverr, sclk, mosi, miso, bootFlashSelectLine_n, e;
    logic         hsel, hwrite, bootDone, bootError, sleeping;
    logic [1:0]   htrans;
    logic [7:0]   lastCmd;
    logic [23:0]  lastAddr;
    int           readCmds, numErrors = 0, samplesChecked = 0, cyc = 0;
    logic [31:0]  wAddr[$], wData[$];
    always #4 mclk = ~mclk;
    spi_flash_boot_loader i_dut (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sclk, .mosi, .miso, .bootFlashSelectLine_n, .hsel,
        .htrans, .haddr, .hwdata, .hwrite, .hready, .bootDone, .bootError);
    sfbl_flash_model i_flash (.mclk, .sclk, .mosi, .csN(bootFlashSelectLine_n), .hdr, .miso,
        .readCmds, .lastCmd, .lastAddr, .sleeping);
    // System bus slave: stalls three cycles in four when asked, logs beats
    always @(posedge mclk) begin
        cyc++;
        hready <= !stall || (cyc % 4) == 0;
        if (dPh && hready) begin
            wData.push_back(hwdata);
            dPh = 1'b0;
        end
        if (hsel && htrans[1] && hready) begin
            wAddr.push_back(haddr);
            dPh = 1'b1;
        end
    end
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        samplesChecked++;
        if (g !== x) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wrchk(input string n, input logic [31:0] d, m, x);
        apb(1'b1, CTRL_OFFSET, d);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(n, x, r & m);
    endtask
    task automatic waitSel(input logic v, output int n);
        for (n = 0; bootFlashSelectLine_n !== v && n < 30000; n++) @(posedge mclk);
        chk("select wait", 32'h0, {31'h0, n >= 30000});
    endtask
    task automatic waitFlag;
        for (int n = 0; bootDone !== 1'b1 && bootError !== 1'b1 && n < 90000; n++)
            @(posedge mclk);
    endtask
    task automatic resetDut;
        rstn <= 1'b0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
    endtask
    function automatic logic [31:0] img(input int i);
        for (int k = 0; k < 4; k++) img[8 * k +: 8] = 8'(4 + 4 * i + k) ^ 8'ha5;
    endfunction
    task automatic t_boot_ok;
        int n, c = 0;
        hdr <= {REQUIRED_ID, 8'h02, 16'h0001};
        stall <= 1'b1;
        resetDut();
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk("ctrl busy", 32'h0, r);
        apb(1'b0, 12'hffc, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
        waitSel(1'b0, n);
        waitSel(1'b1, n);
        waitSel(1'b0, n);
        while (sclk !== 1'b1 && c++ < 100) @(posedge mclk);
        for (n = 0; sclk === 1'b1 && n < 100; n++) @(posedge mclk);
        chk("half period", 32'h5, n);
        waitFlag();
        chk("done", 32'h1, {31'h0, bootDone});
        chk("reads", 32'h2, readCmds);
        chk("command", {24'h0, CMD_READ}, {24'h0, lastCmd});
        chk("address", {8'h0, IMG_ADDR}, {8'h0, lastAddr});
        chk("words", 32'h4, wData.size());
        for (int i = 0; i < 4; i++) begin
            chk("waddr", MEM_BASE + 32'(4 * i), wAddr[i]);
            chk("wdata", img(i), wData[i]);
        end
        stall <= 1'b0;
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk("ctrl idle", 32'h42, r & 32'hfffffffe);
        apb(1'b0, HDR_OFFSET, 32'h0);
        chk("header", hdr, r);
        wrchk("stop zero", 32'h0, 32'h2, 32'h2);
        wrchk("upper", 32'hfffffe00, 32'hfffffe00, 32'h0);
        wrchk("stop clear", 32'h2, 32'h2, 32'h0);
        wrchk("dest", 32'h4, 32'h4, 32'h4);
        wrchk("start", 32'h1, 32'h1, 32'h1);
        wrchk("halt", 32'h2, 32'h1, 32'h0);
    endtask
    task automatic t_boot_err;
        int n, c0;
        hdr <= {8'h11, 8'h02, 16'h0001};
        resetDut();
        c0 = readCmds;
        waitSel(1'b0, n);
        repeat (3) begin
            waitSel(1'b1, n);
            waitSel(1'b0, n);
            chk("gap", 32'h1, {31'h0, n >= RETRY_DELAY_CYC});
        end
        waitFlag();
        chk("error", 32'h1, {31'h0, bootError});
        chk("attempts", 32'h4, readCmds - c0);
        chk("sleep", {24'h0, CMD_DEEP_SLEEP}, {24'h0, lastCmd});
        chk("no image", 32'h4, wAddr.size());
        repeat (200) @(posedge mclk);
        chk("error held", 32'h1, {31'h0, bootError});
        resetDut();
        @(posedge mclk);
        chk("error reset", 32'h0, {31'h0, bootError});
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        t_boot_ok();
        t_boot_err();
        end_sim();
    end
    initial begin
        repeat (120000) @(posedge mclk);
        numErrors++;
        end_sim();
    end
endmodule // tb
